// *** pcm_map.vh ***
// register map, field positions, reset values and timing for the power clock manager
`ifndef PCM_MAP_VH
`define PCM_MAP_VH

// byte offsets of the registers
`define SYS_EN_OFS       8'h00
`define SYS_DIS_OFS      8'h04
`define SYS_STAT_OFS     8'h08
`define PER_EN_OFS       8'h10
`define PER_DIS_OFS      8'h14
`define PER_STAT_OFS     8'h18
`define OSC_CTRL_OFS     8'h20
`define FREQ_MEAS_OFS    8'h24
`define PLL_CFG_OFS      8'h2C
`define MCK_CFG_OFS      8'h30
`define CLK_STAT_OFS     8'h68

// reset values
`define SYS_STAT_RST     6'h01
`define OSC_CTRL_RST     32'h00000000
`define PLL_CFG_RST      32'h00003F00
`define MCK_CFG_RST      32'h00000000

// oscillator control fields
`define OSC_EN_BIT       0
`define OSC_BYP_BIT      1
`define OSC_CNT_LSB      8
`define OSC_CNT_MSB      15
`define OSC_CNT_SHIFT    3

// frequency measure fields
`define FREQ_VALID_BIT   16
`define FREQ_WINDOW      5'h10

// pll config fields
`define PLL_DIV_LSB      0
`define PLL_DIV_MSB      7
`define PLL_CNT_LSB      8
`define PLL_CNT_MSB      13
`define PLL_RNG_LSB      14
`define PLL_RNG_MSB      15
`define PLL_MUL_LSB      16
`define PLL_MUL_MSB      26
`define PLL_USB_LSB      28
`define PLL_USB_MSB      29

// master clock fields and reserved codes
`define MCK_CSS_LSB      0
`define MCK_CSS_MSB      1
`define MCK_CLOCK_RATIO_SELECT_LSB     2
`define MCK_CLOCK_RATIO_SELECT_MSB     4
`define CSS_SLOW         2'h0
`define CSS_MAIN         2'h1
`define CSS_RSVD         2'h2
`define CSS_PLL          2'h3
`define CLOCK_RATIO_SELECT_RSVD        3'h7
`define USB_RSVD         2'h3

// status bit positions
`define STAT_OSC_BIT     0
`define STAT_LOCK_BIT    2
`define STAT_MCK_BIT     3

// timing: system clock and slow clock rates in hertz
`define CLK_HZ           10000000
`define SLOW_HZ          32768
`define SLOW_DIV         (`CLK_HZ / `SLOW_HZ)

`endif

// *** power_clock_manager.v ***
// power clock manager: gating, oscillator, frequency meter, pll and master clock control
//
// Summary of operation
// - a one written to enable bits 2..31 turns that peripheral clock on
// - a one written to disable bits turns that peripheral clock off
// - peripheral status reads one for each enabled clock, zero otherwise
// - unimplemented peripheral bits have no effect and read zero
// - system status shows each programmable clock output enable
// - with oscillator enabled, stable flag rises after the start-up time
// - start-up wait is the count field times 8 slow clock cycles
// - bypass raises the stable flag at once, no start-up wait
// - clearing both enable and bypass clears the stable flag
// - count main clock cycles over 16 slow periods into a 16-bit field
// - valid bit 16 is zero while invalid or disabled, one when available
// - pll input ratio 0 gives no clock, 1 passes, 2..255 divides
// - after each pll write, wait the lock delay in slow cycles then settle
// - pll factor 0 turns the pll off, else output is input times factor+1; here the pll tick keeps the divided rate and only pll_mult_o gives factor+1
// - usb ratio 00 passes, 01 halves, 10 quarters, 11 reserved
// - source 00 slow, 01 main, 11 pll, 10 reserved
// - master ratio codes 000..110 divide by 1..64, 111 reserved
//
// Local design decisions: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/10ps
`include "pcm_map.vh"

module power_clock_manager #(
    parameter [31:0] PERIPH_MASK = 32'hFFFFFFFC,
    parameter        SLOW_DIV    = `SLOW_DIV
) (
    input  wire        clk_i,
    input  wire        rstn_i,
    input  wire        hsel_i,
    input  wire [31:0] haddr_i,
    input  wire [1:0]  htrans_i,
    input  wire        hwrite_i,
    input  wire [2:0]  hsize_i,
    input  wire        hready_i,
    input  wire [31:0] hwdata_i,
    output reg  [31:0] hrdata_o,
    output reg         hreadyout_o,
    output reg         hresp_o,
    output reg  [31:0] periph_clk_en_o,
    output reg  [3:0]  prog_clock_output_o,
    output reg         slow_tick_o,
    output reg         mck_en_o,
    output reg         usb_clk_en_o,
    output reg         pll_active_o,
    output reg  [11:0] pll_mult_o,
    output reg         main_osc_stable_flag_o
);

    // register state
    reg [31:0] per_en_r;
    reg [5:0]  sys_en_r;        // {pck3..pck0, usb, cpu}
    reg [31:0] osc_ctrl_r;
    reg [31:0] pll_cfg_r;
    reg [31:0] mck_cfg_r;
    reg [15:0] main_freq_count_r;
    reg        main_freq_valid_r;
    reg        stable_r;
    reg        osc_run_r;
    reg [10:0] osc_cnt_r;
    reg        lock_r;
    reg [5:0]  lock_cnt_r;
    // bus pipeline
    reg        wr_pend_r;
    reg        rd_pend_r;
    reg [7:0]  addr_r;
    // clock generation
    reg [15:0] slow_cnt_r;
    reg        slow_tick_r;
    reg [4:0]  win_cnt_r;
    reg [15:0] meas_cnt_r;
    reg [7:0]  div_cnt_r;
    reg        div_tick_r;
    reg [1:0]  css_eff_r;
    reg [2:0]  clock_ratio_select_eff_r;
    reg [1:0]  usb_eff_r;
    reg [5:0]  clock_ratio_select_cnt_r;
    reg [1:0]  usb_cnt_r;

    wire        addr_ph   = hsel_i & htrans_i[1] & hready_i;
    wire        wr_now    = wr_pend_r;
    wire [7:0]  pll_div   = pll_cfg_r[`PLL_DIV_MSB:`PLL_DIV_LSB];
    wire [10:0] pll_mul   = pll_cfg_r[`PLL_MUL_MSB:`PLL_MUL_LSB];
    wire        main_tick = stable_r;
    wire        pll_tick  = div_tick_r & (pll_mul != 11'h000) & lock_r;
    wire [1:0]  css_wr    = hwdata_i[`MCK_CSS_MSB:`MCK_CSS_LSB];
    wire [2:0]  clock_ratio_select_wr   = hwdata_i[`MCK_CLOCK_RATIO_SELECT_MSB:`MCK_CLOCK_RATIO_SELECT_LSB];
    wire [1:0]  usb_wr    = hwdata_i[`PLL_USB_MSB:`PLL_USB_LSB];
    wire        osc_on    = osc_ctrl_r[`OSC_EN_BIT] | osc_ctrl_r[`OSC_BYP_BIT];

    reg         src_tick;
    reg [5:0]   clock_ratio_select_max;
    reg [1:0]   usb_max;
    reg [31:0]  rdata;

    // source selection and divider limits
    always @* begin
        case (css_eff_r)
            `CSS_SLOW: src_tick = slow_tick_r;
            `CSS_MAIN: src_tick = main_tick;
            default:   src_tick = pll_tick;
        endcase
        clock_ratio_select_max = 6'h3F >> (3'h6 - clock_ratio_select_eff_r);
        if (clock_ratio_select_eff_r == 3'h0) begin
            clock_ratio_select_max = 6'h00;
        end
        case (usb_eff_r)
            2'h0:    usb_max = 2'h0;
            2'h1:    usb_max = 2'h1;
            default: usb_max = 2'h3;
        endcase
    end

    // read mux
    always @* begin
        rdata = 32'h00000000;
        if (addr_r == `SYS_STAT_OFS) begin
            rdata = {20'h00000, sys_en_r[5:2], sys_en_r[1], 6'h00, sys_en_r[0]};
        end else if (addr_r == `PER_STAT_OFS) begin
            rdata = per_en_r & PERIPH_MASK;
        end else if (addr_r == `OSC_CTRL_OFS) begin
            rdata = osc_ctrl_r;
        end else if (addr_r == `FREQ_MEAS_OFS) begin
            rdata = {15'h0000, main_freq_valid_r, main_freq_count_r};
        end else if (addr_r == `PLL_CFG_OFS) begin
            rdata = pll_cfg_r;
        end else if (addr_r == `MCK_CFG_OFS) begin
            rdata = mck_cfg_r;
        end else if (addr_r == `CLK_STAT_OFS) begin
            rdata = {28'h0000000, 1'b1, lock_r, 1'b0, stable_r};
        end
    end

    // ahb-lite slave: writes take effect in the data phase, reads add one wait
    always @(posedge clk_i) begin
        if (!rstn_i) begin
            wr_pend_r   <= 1'b0;
            rd_pend_r   <= 1'b0;
            addr_r      <= 8'h00;
            hrdata_o    <= 32'h00000000;
            hreadyout_o <= 1'b1;
            hresp_o     <= 1'b0;
        end else begin
            wr_pend_r <= 1'b0;
            // no new address phase can land here: hready is low during the read wait
            if (rd_pend_r) begin
                hrdata_o    <= rdata;
                hreadyout_o <= 1'b1;
                rd_pend_r   <= 1'b0;
            end else if (addr_ph) begin
                addr_r    <= {haddr_i[7:2], 2'b00};
                wr_pend_r <= hwrite_i;
                rd_pend_r <= ~hwrite_i;
                if (!hwrite_i) begin
                    hreadyout_o <= 1'b0;
                end
            end
        end
    end

    // peripheral and system clock enables
    always @(posedge clk_i) begin
        if (!rstn_i) begin
            per_en_r <= 32'h00000000;
            sys_en_r <= `SYS_STAT_RST;
        end else if (wr_now) begin
            if (addr_r == `PER_EN_OFS) begin
                per_en_r <= per_en_r | (hwdata_i & PERIPH_MASK);
            end else if (addr_r == `PER_DIS_OFS) begin
                per_en_r <= per_en_r & ~(hwdata_i & PERIPH_MASK);
            end else if (addr_r == `SYS_EN_OFS) begin
                sys_en_r <= sys_en_r | {hwdata_i[11:8], hwdata_i[7], hwdata_i[0]};
            end else if (addr_r == `SYS_DIS_OFS) begin
                sys_en_r <= sys_en_r & ~{hwdata_i[11:8], hwdata_i[7], hwdata_i[0]};
            end
        end
    end

    // configuration registers, effective copies skip reserved codes
    always @(posedge clk_i) begin
        if (!rstn_i) begin
            osc_ctrl_r <= `OSC_CTRL_RST;
            pll_cfg_r  <= `PLL_CFG_RST;
            mck_cfg_r  <= `MCK_CFG_RST;
            css_eff_r  <= `CSS_SLOW;
            clock_ratio_select_eff_r <= 3'h0;
            usb_eff_r  <= 2'h0;
        end else if (wr_now) begin
            if (addr_r == `OSC_CTRL_OFS) begin
                osc_ctrl_r <= {16'h0000, hwdata_i[15:8], 6'h00, hwdata_i[1:0]};
            end else if (addr_r == `PLL_CFG_OFS) begin
                pll_cfg_r <= {2'b00, hwdata_i[29:28], 1'b0, hwdata_i[26:0]};
                if (usb_wr != `USB_RSVD) begin
                    usb_eff_r <= usb_wr;
                end
            end else if (addr_r == `MCK_CFG_OFS) begin
                mck_cfg_r <= {27'h0000000, hwdata_i[4:0]};
                if (css_wr != `CSS_RSVD) begin
                    css_eff_r <= css_wr;
                end
                if (clock_ratio_select_wr != `CLOCK_RATIO_SELECT_RSVD) begin
                    clock_ratio_select_eff_r <= clock_ratio_select_wr;
                end
            end
        end
    end

    // slow clock enable from a divider of the system clock
    always @(posedge clk_i) begin
        if (!rstn_i) begin
            slow_cnt_r  <= 16'h0000;
            slow_tick_r <= 1'b0;
        end else if (slow_cnt_r == SLOW_DIV[15:0] - 16'h0001) begin
            slow_cnt_r  <= 16'h0000;
            slow_tick_r <= 1'b1;
        end else begin
            slow_cnt_r  <= slow_cnt_r + 16'h0001;
            slow_tick_r <= 1'b0;
        end
    end

    // main oscillator start-up and stable flag
    always @(posedge clk_i) begin
        if (!rstn_i) begin
            stable_r  <= 1'b0;
            osc_run_r <= 1'b0;
            osc_cnt_r <= 11'h000;
        end else if (wr_now && addr_r == `OSC_CTRL_OFS) begin
            // a write outranks the countdown running in the same cycle
            if (hwdata_i[`OSC_BYP_BIT]) begin
                stable_r  <= 1'b1;
                osc_run_r <= 1'b0;
            end else if (hwdata_i[`OSC_EN_BIT]) begin
                if (!stable_r) begin
                    osc_run_r <= 1'b1;
                    osc_cnt_r <= {hwdata_i[`OSC_CNT_MSB:`OSC_CNT_LSB], 3'b000};
                end
            end else begin
                stable_r  <= 1'b0;
                osc_run_r <= 1'b0;
            end
        end else if (osc_run_r) begin
            if (osc_cnt_r == 11'h000) begin
                stable_r  <= 1'b1;
                osc_run_r <= 1'b0;
            end else if (slow_tick_r) begin
                osc_cnt_r <= osc_cnt_r - 11'h001;
            end
        end
    end

    // main clock frequency measurement over 16 slow periods
    always @(posedge clk_i) begin
        if (!rstn_i) begin
            win_cnt_r         <= 5'h00;
            meas_cnt_r        <= 16'h0000;
            main_freq_count_r <= 16'h0000;
            main_freq_valid_r <= 1'b0;
        end else if (!osc_on || !stable_r) begin
            win_cnt_r         <= 5'h00;
            meas_cnt_r        <= 16'h0000;
            main_freq_valid_r <= 1'b0;
        end else begin
            if (meas_cnt_r != 16'hFFFF && win_cnt_r != 5'h00) begin
                meas_cnt_r <= meas_cnt_r + 16'h0001;
            end
            if (slow_tick_r) begin
                if (win_cnt_r == `FREQ_WINDOW) begin
                    // the closing cycle counts too, so the window holds exactly 16 slow periods
                    if (meas_cnt_r == 16'hFFFF) begin
                        main_freq_count_r <= 16'hFFFF;
                    end else begin
                        main_freq_count_r <= meas_cnt_r + 16'h0001;
                    end
                    main_freq_valid_r <= 1'b1;
                    win_cnt_r         <= 5'h01;
                    meas_cnt_r        <= 16'h0000;
                end else begin
                    win_cnt_r <= win_cnt_r + 5'h01;
                end
            end
        end
    end

    // pll lock delay restarts on every pll write
    always @(posedge clk_i) begin
        if (!rstn_i) begin
            lock_r     <= 1'b0;
            lock_cnt_r <= 6'h3F;
        end else if (wr_now && addr_r == `PLL_CFG_OFS) begin
            // any write restarts the delay, even mid-count
            lock_r     <= 1'b0;
            lock_cnt_r <= hwdata_i[`PLL_CNT_MSB:`PLL_CNT_LSB];
        end else if (!lock_r) begin
            if (lock_cnt_r == 6'h00) begin
                lock_r <= 1'b1;
            end else if (slow_tick_r) begin
                lock_cnt_r <= lock_cnt_r - 6'h01;
            end
        end
    end

    // pll input divider on the main clock
    always @(posedge clk_i) begin
        if (!rstn_i) begin
            div_cnt_r  <= 8'h00;
            div_tick_r <= 1'b0;
        end else if (pll_div == 8'h00 || !main_tick) begin
            div_cnt_r  <= 8'h00;
            div_tick_r <= 1'b0;
        end else if (div_cnt_r >= pll_div - 8'h01) begin
            // >= catches a ratio lowered while counting
            div_cnt_r  <= 8'h00;
            div_tick_r <= 1'b1;
        end else begin
            div_cnt_r  <= div_cnt_r + 8'h01;
            div_tick_r <= 1'b0;
        end
    end

    // master clock prescaler and usb divider
    always @(posedge clk_i) begin
        if (!rstn_i) begin
            clock_ratio_select_cnt_r <= 6'h00;
            usb_cnt_r  <= 2'h0;
            mck_en_o   <= 1'b0;
            usb_clk_en_o <= 1'b0;
        end else begin
            mck_en_o     <= 1'b0;
            usb_clk_en_o <= 1'b0;
            if (src_tick) begin
                if (clock_ratio_select_cnt_r >= clock_ratio_select_max) begin
                    // >= recovers when a smaller ratio is loaded mid-count
                    clock_ratio_select_cnt_r <= 6'h00;
                    mck_en_o   <= 1'b1;
                end else begin
                    clock_ratio_select_cnt_r <= clock_ratio_select_cnt_r + 6'h01;
                end
            end
            if (pll_tick) begin
                if (usb_cnt_r >= usb_max) begin
                    usb_cnt_r    <= 2'h0;
                    usb_clk_en_o <= 1'b1;
                end else begin
                    usb_cnt_r <= usb_cnt_r + 2'h1;
                end
            end
        end
    end

    // registered level outputs and the slow tick pulse
    always @(posedge clk_i) begin
        if (!rstn_i) begin
            periph_clk_en_o        <= 32'h00000000;
            prog_clock_output_o    <= 4'h0;
            slow_tick_o            <= 1'b0;
            pll_active_o           <= 1'b0;
            pll_mult_o             <= 12'h000;
            main_osc_stable_flag_o <= 1'b0;
        end else begin
            periph_clk_en_o        <= per_en_r & PERIPH_MASK;
            prog_clock_output_o    <= sys_en_r[5:2];
            slow_tick_o            <= slow_tick_r;
            pll_active_o           <= (pll_mul != 11'h000) & lock_r;
            pll_mult_o             <= (pll_mul == 11'h000) ? 12'h000 : {1'b0, pll_mul} + 12'h001;
            main_osc_stable_flag_o <= stable_r;
        end
    end

endmodule

// *** pcm_sva.sv ***
// checker for the power clock manager ports
`timescale 1ns/10ps
module pcm_sva #(
    parameter SLOW_DIV = 4
) (
    input wire        clk_i,
    input wire        rstn_i,
    input wire        hsel_i,
    input wire [1:0]  htrans_i,
    input wire        hwrite_i,
    input wire        hready_i,
    input wire [31:0] hrdata_o,
    input wire        hreadyout_o,
    input wire        hresp_o,
    input wire [31:0] periph_clk_en_o,
    input wire        slow_tick_o,
    input wire        pll_active_o,
    input wire [11:0] pll_mult_o
);
    logic [15:0] gap_r;
    logic        seen_r;

    default clocking @(posedge clk_i); endclocking
    default disable iff (!rstn_i);

    // cycles since the last slow tick
    always @(posedge clk_i) begin
        if (!rstn_i) begin
            gap_r  <= 16'h0000;
            seen_r <= 1'b0;
        end else if (slow_tick_o) begin
            gap_r  <= 16'h0000;
            seen_r <= 1'b1;
        end else begin
            gap_r  <= gap_r + 16'h0001;
        end
    end

    a_resp_okay: assert property (hresp_o == 1'b0)
        else $error("error response seen");
    a_read_wait: assert property (hsel_i && htrans_i[1] && hready_i && !hwrite_i
        |=> !hreadyout_o ##1 hreadyout_o) else $error("read wait not one cycle");
    a_write_nowait: assert property (hsel_i && htrans_i[1] && hready_i && hwrite_i
        |=> hreadyout_o) else $error("write stalled");
    a_rdata_hold: assert property (hreadyout_o && $past(hreadyout_o) |-> $stable(hrdata_o))
        else $error("read data moved");
    a_low_bits: assert property (periph_clk_en_o[1:0] == 2'h0)
        else $error("reserved clock bit set");
    a_tick_gap: assert property (seen_r && slow_tick_o |-> gap_r == 16'(SLOW_DIV - 1))
        else $error("slow tick period wrong");
    a_tick_pulse: assert property (slow_tick_o |=> !slow_tick_o)
        else $error("slow tick too long");
    a_pll_off: assert property (pll_mult_o == 12'h000 |-> !pll_active_o)
        else $error("pll active with zero factor");

    c_read: cover property (hsel_i && htrans_i[1] && !hwrite_i);
    c_lock: cover property ($rose(pll_active_o));
    c_tick: cover property (slow_tick_o);
endmodule

bind power_clock_manager pcm_sva #(.SLOW_DIV(SLOW_DIV)) u_sva (.clk_i(clk_i), .rstn_i(rstn_i),
    .hsel_i(hsel_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hready_i(hready_i),
    .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
    .periph_clk_en_o(periph_clk_en_o), .slow_tick_o(slow_tick_o),
    .pll_active_o(pll_active_o), .pll_mult_o(pll_mult_o));

// *** power_clock_manager_tb_top.sv ***
// testbench for the power clock manager
`timescale 1ns/10ps
`include "pcm_map.vh"
module power_clock_manager_tb_top;
    logic        clk_i = 1'b0;
    logic        rstn_i = 1'b0;
    logic        hsel_i = 1'b0;
    logic        hwrite_i = 1'b0;
    logic [1:0]  htrans_i = 2'h0;
    logic [31:0] haddr_i = 32'h0;
    logic [31:0] hwdata_i = 32'h0;
    wire  [31:0] hrdata_o;
    wire         hreadyout_o;
    wire  [31:0] periph_clk_en_o;
    wire  [3:0]  prog_clock_output_o;
    wire         mck_en_o;
    wire         usb_clk_en_o;
    wire         pll_active_o;
    wire  [11:0] pll_mult_o;
    wire         main_osc_stable_flag_o;
    int          err_total = 0;
    int          tests_run = 0;

    power_clock_manager #(.SLOW_DIV(4)) i_dut (.clk_i(clk_i), .rstn_i(rstn_i), .hsel_i(hsel_i),
        .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2),
        .hready_i(hreadyout_o), .hwdata_i(hwdata_i), .hrdata_o(hrdata_o),
        .hreadyout_o(hreadyout_o), .hresp_o(), .periph_clk_en_o(periph_clk_en_o),
        .prog_clock_output_o(prog_clock_output_o), .slow_tick_o(), .mck_en_o(mck_en_o),
        .usb_clk_en_o(usb_clk_en_o), .pll_active_o(pll_active_o), .pll_mult_o(pll_mult_o),
        .main_osc_stable_flag_o(main_osc_stable_flag_o));

    // 10 MHz clock
    always #50 clk_i = ~clk_i;

    task chk(input logic [31:0] s, input logic [31:0] e);
        begin
            tests_run++;
            if (s !== e) begin
                err_total++;
                $display("wrong value at %0t: seen %h expected %h", $time, s, e);
            end
        end
    endtask

    task final_report;
        begin
            $display("checks %0d mismatches %0d", tests_run, err_total);
            if (err_total == 0 && tests_run > 0) begin
                $display("All checks passed");
            end else begin
                $display("Checks failed");
            end
            $finish;
        end
    endtask

    // one single-word bus transfer
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        begin
            hsel_i   <= 1'b1;
            haddr_i  <= {24'h000000, a};
            hwrite_i <= w;
            htrans_i <= 2'h2;
            @(posedge clk_i);
            while (hreadyout_o !== 1'b1) @(posedge clk_i);
            htrans_i <= 2'h0;
            hwdata_i <= d;
            @(posedge clk_i);
            while (hreadyout_o !== 1'b1) @(posedge clk_i);
            q = hrdata_o;
        end
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        begin
            xfer(1'b1, a, d, q);
        end
    endtask

    task rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        begin
            xfer(1'b0, a, 32'h0, q);
            chk(q, e);
        end
    endtask

    // count master and usb pulses over 64 cycles after settling
    task meas(input logic [31:0] em, input logic [31:0] eu);
        int m;
        int u;
        begin
            m = 0;
            u = 0;
            repeat (130) @(posedge clk_i);
            repeat (64) begin
                @(posedge clk_i);
                m += (mck_en_o === 1'b1);
                u += (usb_clk_en_o === 1'b1);
            end
            chk(m, em);
            chk(u, eu);
        end
    endtask

    task t_regs;
        begin
            rd(`PER_STAT_OFS, 32'h0);
            rd(`OSC_CTRL_OFS, 32'h0);
            rd(`FREQ_MEAS_OFS, 32'h0);
            rd(`PLL_CFG_OFS, 32'h00003F00);
            rd(`MCK_CFG_OFS, 32'h0);
            rd(8'h28, 32'h0);
            rd(`SYS_STAT_OFS, 32'h1);
            wr(`SYS_EN_OFS, 32'h00000F00);
            rd(`SYS_STAT_OFS, 32'h00000F01);
            chk({28'h0, prog_clock_output_o}, 32'hF);
            wr(`SYS_DIS_OFS, 32'h00000500);
            rd(`SYS_STAT_OFS, 32'h00000A01);
            chk({28'h0, prog_clock_output_o}, 32'hA);
        end
    endtask

    task t_periph;
        begin
            wr(`PER_EN_OFS, 32'hFFFFFFFF);
            rd(`PER_STAT_OFS, 32'hFFFFFFFC);
            chk(periph_clk_en_o, 32'hFFFFFFFC);
            wr(`PER_DIS_OFS, 32'h00000110);
            wr(`PER_EN_OFS, 32'h0);
            rd(`PER_STAT_OFS, 32'hFFFFFEEC);
            wr(`PER_DIS_OFS, 32'hFFFFFFFF);
            rd(`PER_STAT_OFS, 32'h0);
            chk(periph_clk_en_o, 32'h0);
        end
    endtask

    task t_osc;
        begin
            wr(`OSC_CTRL_OFS, 32'h2);
            repeat (2) @(posedge clk_i);
            chk(main_osc_stable_flag_o, 1);
            wr(`OSC_CTRL_OFS, 32'h0);
            repeat (2) @(posedge clk_i);
            chk(main_osc_stable_flag_o, 0);
            wr(`OSC_CTRL_OFS, 32'h00000101);
            repeat (24) @(posedge clk_i);
            chk(main_osc_stable_flag_o, 0);
            repeat (16) @(posedge clk_i);
            chk(main_osc_stable_flag_o, 1);
            repeat (160) @(posedge clk_i);
            rd(`FREQ_MEAS_OFS, 32'h00010040);
        end
    endtask

    task t_pll;
        begin
            wr(`PLL_CFG_OFS, 32'h00030201);
            chk(pll_active_o, 0);
            repeat (3) @(posedge clk_i);
            chk(pll_active_o, 0);
            repeat (8) @(posedge clk_i);
            chk(pll_active_o, 1);
            chk(pll_mult_o, 12'h004);
            rd(`PLL_CFG_OFS, 32'h00030201);
            wr(`PLL_CFG_OFS, 32'h00030201);
            repeat (2) @(posedge clk_i);
            chk(pll_active_o, 0);
        end
    endtask

    task t_clocks;
        int p;
        begin
            for (p = 0; p < 7; p++) begin
                wr(`MCK_CFG_OFS, {27'h0, p[2:0], 2'h1});
                meas(64 >> p, 64);
            end
            wr(`MCK_CFG_OFS, 32'h1A);
            meas(1, 64);
            wr(`MCK_CFG_OFS, 32'h0);
            meas(16, 64);
            wr(`MCK_CFG_OFS, 32'h3);
            meas(64, 64);
            wr(`PLL_CFG_OFS, 32'h10030102);
            meas(32, 16);
            wr(`PLL_CFG_OFS, 32'h20030101);
            meas(64, 16);
            wr(`PLL_CFG_OFS, 32'h30030101);
            meas(64, 16);
            wr(`PLL_CFG_OFS, 32'h00030100);
            meas(0, 0);
            wr(`PLL_CFG_OFS, 32'h00000101);
            meas(0, 0);
            chk(pll_mult_o, 12'h000);
        end
    endtask

    task t_off;
        begin
            wr(`OSC_CTRL_OFS, 32'h0);
            repeat (2) @(posedge clk_i);
            rd(`FREQ_MEAS_OFS, 32'h00000040);
            chk(main_osc_stable_flag_o, 0);
        end
    endtask

    // main sequence
    initial begin
        repeat (6) @(posedge clk_i);
        rstn_i <= 1'b1;
        @(posedge clk_i);
        t_regs;
        t_periph;
        t_osc;
        t_pll;
        t_clocks;
        t_off;
        final_report;
    end

    // hang guard
    initial begin
        repeat (30000) @(posedge clk_i);
        err_total++;
        final_report;
    end
endmodule
